/* src/hrosc_map.svh */
// constants for the hard reset and output state control
`ifndef HROSC_MAP_SVH
`define HROSC_MAP_SVH
`define HROSC_RST_MIN_CYC      50
`define HROSC_CLK_AFTER_CYC    10
`define HROSC_CLK_BEFORE_CYC   10
`define HROSC_FIRST_CMD_CYC    100
`define HROSC_CNT_W            8
`define HROSC_GPIO_W           4
`define HROSC_DOUT_W           16
`define HROSC_SAMPLE_CYC       4
`endif

/* src/hrosc_pkg.sv */
// types for the hard reset and output state control
package hrosc_pkg;
    typedef enum logic [2:0] {
        ST_RESET,
        ST_SAMPLE,
        ST_DEFAULT,
        ST_STANDBY,
        ST_RUN
    } hrosc_state_e;
    typedef enum logic [2:0] {
        H_IDLE,
        H_ASSERT,
        H_HOLD,
        H_PRE,
        H_WAIT,
        H_READY
    } hrosc_host_e;
endpackage : hrosc_pkg

/* src/hrosc_if.sv */
// link between host controller and the device end
`timescale 1ns/100ps
interface hrosc_if;
    logic        reset_n;
    logic        ref_clock_in;
    logic        serial_start;
    logic        slave_addr_select;
    logic        frame_sync;
    logic        standby;
    logic        test_reset_n;
    logic        sensor_frame_valid;
    logic        sensor_line_valid;
    logic        sensor_pixel_clock;
    logic [3:0]  gpio_in;
    logic        sensor_reset_n_out;
    logic        sensor_reset_n_oe_n;
    logic        frame_valid_out;
    logic        line_valid_out;
    logic        pixel_clock_out;
    logic [15:0] video_data_out;
    logic        video_oe_n;
    logic [3:0]  gpio_out;
    logic [3:0]  gpio_oe_n;
    logic        trigger_out;
    logic        trigger_oe_n;
    modport device (
        input  reset_n, ref_clock_in, serial_start, slave_addr_select, frame_sync, standby,
        input  test_reset_n, sensor_frame_valid, sensor_line_valid, sensor_pixel_clock,
        input  gpio_in,
        output sensor_reset_n_out, sensor_reset_n_oe_n, frame_valid_out, line_valid_out,
        output pixel_clock_out, video_data_out, video_oe_n, gpio_out, gpio_oe_n,
        output trigger_out, trigger_oe_n
    );
    modport host (
        output reset_n, ref_clock_in, serial_start, slave_addr_select, frame_sync, standby,
        output test_reset_n, sensor_frame_valid, sensor_line_valid, sensor_pixel_clock,
        output gpio_in,
        input  sensor_reset_n_out, sensor_reset_n_oe_n, frame_valid_out, line_valid_out,
        input  pixel_clock_out, video_data_out, video_oe_n, gpio_out, gpio_oe_n,
        input  trigger_out, trigger_oe_n
    );
endinterface : hrosc_if

/* src/hrosc_device.sv */
// device end: reset entry and exit, output pin states
// Behaviour
// - reset held while reset input low
// - all outputs floated during reset
// - host clocks ten cycles after assert
// - host clocks ten cycles before release
// - no serial command before 100 cycles
// - sensor reset low, high after release
// - video outputs float, driven if used
// - upper gpio sampled, float until release, driven if used
// - host holds inputs at valid levels
// - host keeps test reset negated
// - serial soft reset restarts sequence
// - power-on reset acts as hard reset
`timescale 1ns/100ps
`include "hrosc_map.svh"
module hrosc_device #(
    parameter int SAMPLE_CYC = `HROSC_SAMPLE_CYC
) (
    hrosc_if.device                       lnk,
    input  wire logic                     core_clk,
    input  wire logic                     nrst,
    input  wire logic                     soft_reset_req,
    input  wire logic                     fw_release_sensor,
    input  wire logic                     video_used,
    input  wire logic                     stream_en,
    input  wire logic                     trigger_used,
    input  wire logic [15:0]              video_data,
    input  wire logic                     video_fv,
    input  wire logic                     video_lv,
    input  wire logic [3:0]               gpio_drive,
    input  wire logic [3:0]               gpio_used,
    output logic      [3:0]               boot_config,
    output logic                          boot_config_valid,
    output logic                          in_reset
);
    // reset synchroniser, por clears it
    logic [1:0] rst_sync;
    logic       int_rst_n;
    always_ff @(posedge core_clk or negedge lnk.reset_n) begin
        if (!lnk.reset_n) begin
            rst_sync <= 2'h0;
        end else if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign int_rst_n = rst_sync[1];
    assign in_reset  = ~int_rst_n;

    // frame sync input, three stages
    logic [2:0] fs_sync;
    logic [2:0] next_fs_sync;
    logic       fs_level;
    logic       next_fs_level;
    always_comb begin
        next_fs_sync  = {fs_sync[1:0], lnk.frame_sync};
        next_fs_level = fs_level;
        if (fs_sync[1] == fs_sync[2]) begin
            next_fs_level = fs_sync[2];
        end
    end
    always_ff @(posedge core_clk) begin
        if (!int_rst_n) begin
            fs_sync  <= 3'h0;
            fs_level <= 1'b0;
        end else begin
            fs_sync  <= next_fs_sync;
            fs_level <= next_fs_level;
        end
    end

    // standby input, three stages
    logic [2:0] sb_sync;
    logic [2:0] next_sb_sync;
    logic       sb_level;
    logic       next_sb_level;
    always_comb begin
        next_sb_sync  = {sb_sync[1:0], lnk.standby};
        next_sb_level = sb_level;
        if (sb_sync[1] == sb_sync[2]) begin
            next_sb_level = sb_sync[2];
        end
    end
    always_ff @(posedge core_clk) begin
        if (!int_rst_n) begin
            sb_sync  <= 3'h0;
            sb_level <= 1'b0;
        end else begin
            sb_sync  <= next_sb_sync;
            sb_level <= next_sb_level;
        end
    end

    // gpio strap sampling, three stages
    logic [3:0] gp_s1, gp_s2, gp_s3;
    always_ff @(posedge core_clk) begin
        gp_s1 <= lnk.gpio_in;
        gp_s2 <= gp_s1;
        gp_s3 <= gp_s2;
    end

    // state machine
    hrosc_pkg::hrosc_state_e state;
    hrosc_pkg::hrosc_state_e next_state;
    logic [`HROSC_CNT_W-1:0] cnt;
    logic [`HROSC_CNT_W-1:0] next_cnt;
    logic [3:0]              next_boot_config;
    logic                    next_boot_config_valid;
    always_comb begin
        next_state             = state;
        next_cnt               = cnt;
        next_boot_config       = boot_config;
        next_boot_config_valid = boot_config_valid;
        case (state)
            hrosc_pkg::ST_RESET: begin
                next_state = hrosc_pkg::ST_SAMPLE;
                next_cnt   = '0;
            end
            hrosc_pkg::ST_SAMPLE: begin
                next_cnt = cnt + 1'b1;
                if (gp_s2 == gp_s3 && cnt >= (`HROSC_CNT_W)'(SAMPLE_CYC)) begin
                    next_boot_config       = gp_s3;
                    next_boot_config_valid = 1'b1;
                    next_state             = hrosc_pkg::ST_DEFAULT;
                end
            end
            hrosc_pkg::ST_DEFAULT: begin
                if (fw_release_sensor) begin
                    next_state = hrosc_pkg::ST_STANDBY;
                end
            end
            hrosc_pkg::ST_STANDBY: begin
                if (!sb_level && (stream_en || fs_level)) begin
                    next_state = hrosc_pkg::ST_RUN;
                end
            end
            hrosc_pkg::ST_RUN: begin
                if (sb_level || !stream_en) begin
                    next_state = hrosc_pkg::ST_STANDBY;
                end
            end
            default: begin
                next_state = hrosc_pkg::ST_RESET;
            end
        endcase
        if (soft_reset_req) begin
            next_state             = hrosc_pkg::ST_RESET;
            next_boot_config_valid = 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!int_rst_n) begin
            state             <= hrosc_pkg::ST_RESET;
            cnt               <= '0;
            boot_config       <= 4'h0;
            boot_config_valid <= 1'b0;
        end else begin
            state             <= next_state;
            cnt               <= next_cnt;
            boot_config       <= next_boot_config;
            boot_config_valid <= next_boot_config_valid;
        end
    end

    // output pin registers
    logic        released;
    logic        next_released;
    logic        vid_oe;
    logic        next_vid_oe;
    logic        fv_q, lv_q, pclk_q;
    logic        next_fv_q, next_lv_q, next_pclk_q;
    logic [15:0] vd_q;
    logic [15:0] next_vd_q;
    logic [3:0]  gp_q, gp_oe;
    logic [3:0]  next_gp_q, next_gp_oe;
    logic        trg_q, trg_oe;
    logic        next_trg_q, next_trg_oe;
    logic        active;
    always_comb begin
        active        = (state == hrosc_pkg::ST_STANDBY) || (state == hrosc_pkg::ST_RUN);
        next_released = active;
        next_vid_oe   = active && video_used;
        next_fv_q     = (state == hrosc_pkg::ST_RUN) && video_fv;
        next_lv_q     = (state == hrosc_pkg::ST_RUN) && video_lv;
        next_pclk_q   = (state == hrosc_pkg::ST_RUN) ? ~pclk_q : 1'b0;
        next_vd_q     = (state == hrosc_pkg::ST_RUN) ? video_data : 16'h0000;
        next_gp_oe    = active ? gpio_used : 4'h0;
        next_gp_q     = gpio_drive;
        next_trg_oe   = active && trigger_used;
        next_trg_q    = fs_level && active;
    end
    always_ff @(posedge core_clk) begin
        if (!int_rst_n) begin
            released <= 1'b0;
            vid_oe   <= 1'b0;
            fv_q     <= 1'b0;
            lv_q     <= 1'b0;
            pclk_q   <= 1'b0;
            vd_q     <= 16'h0000;
            gp_q     <= 4'h0;
            gp_oe    <= 4'h0;
            trg_q    <= 1'b0;
            trg_oe   <= 1'b0;
        end else begin
            released <= next_released;
            vid_oe   <= next_vid_oe;
            fv_q     <= next_fv_q;
            lv_q     <= next_lv_q;
            pclk_q   <= next_pclk_q;
            vd_q     <= next_vd_q;
            gp_q     <= next_gp_q;
            gp_oe    <= next_gp_oe;
            trg_q    <= next_trg_q;
            trg_oe   <= next_trg_oe;
        end
    end

    // pins float while reset is held
    assign lnk.sensor_reset_n_out  = released;
    assign lnk.sensor_reset_n_oe_n = ~int_rst_n;
    assign lnk.frame_valid_out     = fv_q;
    assign lnk.line_valid_out      = lv_q;
    assign lnk.pixel_clock_out     = pclk_q;
    assign lnk.video_data_out      = vd_q;
    assign lnk.video_oe_n          = ~(int_rst_n && vid_oe);
    assign lnk.gpio_out            = gp_q;
    assign lnk.gpio_oe_n           = ~(gp_oe & {4{int_rst_n}});
    assign lnk.trigger_out         = trg_q;
    assign lnk.trigger_oe_n        = ~(int_rst_n && trg_oe);
endmodule : hrosc_device

/* src/hrosc_host.sv */
// host end: drives reset, reference clock and static inputs
`timescale 1ns/100ps
`include "hrosc_map.svh"
module hrosc_host #(
    parameter int CLK_DIV = 2
) (
    hrosc_if.host                 lnk,
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic             reset_req,
    input  wire logic             addr_sel,
    input  wire logic             sync_req,
    input  wire logic             standby_req,
    input  wire logic [3:0]       strap,
    output logic                  serial_ok,
    output logic                  busy
);
    hrosc_pkg::hrosc_host_e  st;
    hrosc_pkg::hrosc_host_e  next_st;
    logic [`HROSC_CNT_W-1:0] cnt;
    logic [`HROSC_CNT_W-1:0] next_cnt;
    logic [7:0]              div;
    logic [7:0]              next_div;
    logic                    rclk;
    logic                    next_rclk;
    logic                    rise;
    always_comb begin
        next_div  = div + 8'h01;
        next_rclk = rclk;
        if (div == 8'(CLK_DIV - 1)) begin
            next_div  = 8'h00;
            next_rclk = ~rclk;
        end
        rise     = (div == 8'(CLK_DIV - 1)) && !rclk;
        next_st  = st;
        next_cnt = cnt;
        case (st)
            hrosc_pkg::H_IDLE: begin
                if (reset_req) begin
                    next_st  = hrosc_pkg::H_ASSERT;
                    next_cnt = '0;
                end
            end
            hrosc_pkg::H_ASSERT: begin
                if (rise) begin
                    next_cnt = cnt + 1'b1;
                end
                if (rise && cnt == `HROSC_CNT_W'(`HROSC_CLK_AFTER_CYC - 1)) begin
                    next_st = hrosc_pkg::H_HOLD;
                end
            end
            hrosc_pkg::H_HOLD: begin
                if (rise) begin
                    next_cnt = cnt + 1'b1;
                end
                if (rise && cnt == `HROSC_CNT_W'(`HROSC_RST_MIN_CYC)) begin
                    next_st  = hrosc_pkg::H_WAIT;
                    next_cnt = '0;
                end
            end
            hrosc_pkg::H_WAIT: begin
                if (rise) begin
                    next_cnt = cnt + 1'b1;
                end
                if (rise && cnt == `HROSC_CNT_W'(`HROSC_FIRST_CMD_CYC - 1)) begin
                    next_st = hrosc_pkg::H_READY;
                end
            end
            hrosc_pkg::H_READY: begin
                if (reset_req) begin
                    next_st  = hrosc_pkg::H_ASSERT;
                    next_cnt = '0;
                end
            end
            default: begin
                next_st = hrosc_pkg::H_IDLE;
            end
        endcase
    end
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st   <= hrosc_pkg::H_ASSERT;
            cnt  <= '0;
            div  <= 8'h00;
            rclk <= 1'b0;
        end else begin
            st   <= next_st;
            cnt  <= next_cnt;
            div  <= next_div;
            rclk <= next_rclk;
        end
    end
    assign lnk.ref_clock_in       = rclk;
    assign lnk.reset_n            = !(st == hrosc_pkg::H_ASSERT || st == hrosc_pkg::H_HOLD);
    assign lnk.serial_start       = (st == hrosc_pkg::H_READY);
    assign lnk.slave_addr_select  = addr_sel;
    assign lnk.frame_sync         = sync_req;
    assign lnk.standby            = standby_req;
    assign lnk.test_reset_n       = 1'b1;
    assign lnk.sensor_frame_valid = 1'b0;
    assign lnk.sensor_line_valid  = 1'b0;
    assign lnk.sensor_pixel_clock = 1'b0;
    assign lnk.gpio_in            = strap;
    assign serial_ok              = (st == hrosc_pkg::H_READY);
    assign busy                   = (st != hrosc_pkg::H_READY) && (st != hrosc_pkg::H_IDLE);
endmodule : hrosc_host

/* verif/hrosc_checker.sv */
// assertions on the link between host and device ends
`timescale 1ns/100ps
module hrosc_checker (
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       reset_n,
    input wire logic       ref_clock_in,
    input wire logic       serial_start,
    input wire logic       test_reset_n,
    input wire logic       sensor_reset_n_out,
    input wire logic       sensor_reset_n_oe_n,
    input wire logic       video_oe_n,
    input wire logic [3:0] gpio_oe_n,
    input wire logic       trigger_oe_n
);
    logic       ref_q;
    logic       ref_rise;
    logic [7:0] low_cnt;
    logic [7:0] high_cnt;
    logic [3:0] idle_cnt;
    assign ref_rise = ref_clock_in & ~ref_q;
    // ref rises counted in and out of reset, idle time of ref
    always_ff @(posedge core_clk) begin
        ref_q <= ref_clock_in;
        if (!nrst) begin
            low_cnt  <= 8'h00;
            high_cnt <= 8'h00;
            idle_cnt <= 4'h0;
        end else begin
            low_cnt  <= reset_n ? 8'h00 : low_cnt + 8'(ref_rise && low_cnt != 8'hff);
            high_cnt <= !reset_n ? 8'h00 : high_cnt + 8'(ref_rise && high_cnt != 8'hff);
            idle_cnt <= (ref_clock_in != ref_q) ? 4'h0 : idle_cnt + 4'(idle_cnt != 4'hf);
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    a_reset_floats: assert property (!reset_n |-> (sensor_reset_n_oe_n && video_oe_n
        && trigger_oe_n && gpio_oe_n == 4'hf)) else $error("output driven during reset");
    a_reset_width: assert property ($rose(reset_n) |-> low_cnt >= 8'd50)
        else $error("reset pulse too short");
    a_clock_runs: assert property (!reset_n |-> idle_cnt < 4'h8)
        else $error("ref clock stopped in reset");
    a_serial_wait: assert property ((reset_n && high_cnt < 8'd100) |-> !serial_start)
        else $error("serial start too early");
    a_sensor_low: assert property ($rose(reset_n) |->
        (sensor_reset_n_oe_n || !sensor_reset_n_out) [*8]) else $error("sensor reset released");
    a_video_float: assert property ($rose(reset_n) |-> (video_oe_n && trigger_oe_n) [*8])
        else $error("video or trigger driven early");
    a_gpio_float: assert property ($rose(reset_n) |-> (gpio_oe_n == 4'hf) [*8])
        else $error("gpio driven during sampling");
    a_test_reset: assert property (reset_n |-> test_reset_n)
        else $error("test reset asserted");
endmodule : hrosc_checker

/* verif/hrosc_tb_top.sv */
// testbench joining host and device ends
`timescale 1ns/100ps
module hrosc_tb_top;
    localparam int CLK_DIV = 2;
    logic        core_clk, nrst, reset_req, addr_sel, sync_req, standby_req, serial_ok;
    logic        soft_reset_req, fw_release_sensor, video_used, stream_en, trigger_used;
    logic        video_fv, video_lv, boot_config_valid, in_reset;
    logic [3:0]  strap, gpio_drive, gpio_used, boot_config;
    logic [15:0] video_data;
    logic [3:0]  strap_q[$];
    int          miscompares = 0;
    int          comparisons = 0;
    int          cyc = 0;
    integer      seed = 32'h18298b96;
    hrosc_if hrosc_if_i ();
    hrosc_host #(.CLK_DIV(CLK_DIV)) hrosc_host_i (.lnk(hrosc_if_i), .core_clk(core_clk),
        .nrst(nrst), .reset_req(reset_req), .addr_sel(addr_sel), .sync_req(sync_req),
        .standby_req(standby_req), .strap(strap), .serial_ok(serial_ok), .busy());
    hrosc_device hrosc_device_i (.lnk(hrosc_if_i), .core_clk(core_clk), .nrst(nrst),
        .soft_reset_req(soft_reset_req), .fw_release_sensor(fw_release_sensor),
        .video_used(video_used), .stream_en(stream_en), .trigger_used(trigger_used),
        .video_data(video_data), .video_fv(video_fv), .video_lv(video_lv),
        .gpio_drive(gpio_drive), .gpio_used(gpio_used), .boot_config(boot_config),
        .boot_config_valid(boot_config_valid), .in_reset(in_reset));
    hrosc_checker hrosc_checker_i (.core_clk(core_clk), .nrst(nrst),
        .reset_n(hrosc_if_i.reset_n), .ref_clock_in(hrosc_if_i.ref_clock_in),
        .serial_start(hrosc_if_i.serial_start), .test_reset_n(hrosc_if_i.test_reset_n),
        .sensor_reset_n_out(hrosc_if_i.sensor_reset_n_out),
        .sensor_reset_n_oe_n(hrosc_if_i.sensor_reset_n_oe_n),
        .video_oe_n(hrosc_if_i.video_oe_n), .gpio_oe_n(hrosc_if_i.gpio_oe_n),
        .trigger_oe_n(hrosc_if_i.trigger_oe_n));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;
    task tally_and_finish;
        if (miscompares == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // new random levels for every free input; strap goes to the model queue
    task rand_in;
        logic [31:0] r;
        r = $random(seed);
        strap <= r[3:0];
        strap_q.push_back(r[3:0]);
        gpio_drive <= r[7:4];
        gpio_used <= r[11:8];
        {video_used, trigger_used, stream_en, sync_req} <= r[15:12];
        {standby_req, addr_sel, video_fv, video_lv} <= r[19:16];
        video_data <= r[31:16];
    endtask : rand_in
    task wait_rst(input logic lvl);
        for (int i = 0; i < 2000 && hrosc_if_i.reset_n !== lvl; i++) @(posedge core_clk);
        chk({15'h0, hrosc_if_i.reset_n}, {15'h0, lvl});
    endtask : wait_rst
    // kind 0 hard reset by host, 1 power-on style reset, 2 soft reset
    task round(input int kind);
        int   t_rel;
        logic run;
        logic pclk;
        t_rel = 0;
        @(posedge core_clk);
        fw_release_sensor <= 1'b0;
        rand_in;
        if (kind != 1) repeat (8) @(posedge core_clk);
        if (kind == 0) reset_req <= 1'b1;
        else if (kind == 1) nrst <= 1'b0;
        else soft_reset_req <= 1'b1;
        @(posedge core_clk);
        reset_req <= 1'b0;
        soft_reset_req <= 1'b0;
        if (kind == 1) begin
            repeat (13) @(posedge core_clk);
            #1;
            chk({15'h0, in_reset}, 16'h0001);
            @(posedge core_clk);
            nrst <= 1'b1;
        end
        if (kind != 2) begin
            wait_rst(1'b0);
            #1;
            chk({8'h00, in_reset, hrosc_if_i.video_oe_n, hrosc_if_i.trigger_oe_n,
                hrosc_if_i.sensor_reset_n_oe_n, hrosc_if_i.gpio_oe_n}, 16'h00ff);
            wait_rst(1'b1);
            t_rel = cyc;
        end else begin
            for (int i = 0; i < 20 && boot_config_valid !== 1'b0; i++) @(posedge core_clk);
            chk({15'h0, boot_config_valid}, 16'h0000);
        end
        for (int i = 0; i < 50 && in_reset !== 1'b0; i++) @(posedge core_clk);
        for (int i = 0; i < 1000 && boot_config_valid !== 1'b1; i++) @(posedge core_clk);
        repeat (2) @(posedge core_clk);
        #1;
        chk({12'h000, boot_config}, {12'h000, strap_q.pop_front()});
        chk({8'h00, hrosc_if_i.gpio_oe_n, hrosc_if_i.video_oe_n, hrosc_if_i.trigger_oe_n,
            hrosc_if_i.sensor_reset_n_oe_n, hrosc_if_i.sensor_reset_n_out}, 16'h00fc);
        @(posedge core_clk);
        fw_release_sensor <= 1'b1;
        repeat (12) @(posedge core_clk);
        #1;
        chk({12'h000, hrosc_if_i.video_oe_n, hrosc_if_i.trigger_oe_n,
            hrosc_if_i.sensor_reset_n_oe_n, hrosc_if_i.sensor_reset_n_out},
            {12'h000, !video_used, !trigger_used, 2'b01});
        chk({8'h00, hrosc_if_i.gpio_oe_n, hrosc_if_i.gpio_out & gpio_used},
            {8'h00, ~gpio_used, gpio_drive & gpio_used});
        chk({15'h0, hrosc_if_i.trigger_out}, {15'h0, sync_req});
        if (standby_req || stream_en || !sync_req) begin
            run = stream_en && !standby_req;
            chk(hrosc_if_i.video_data_out, run ? video_data : 16'h0000);
            chk({14'h0, hrosc_if_i.frame_valid_out, hrosc_if_i.line_valid_out},
                {14'h0, video_fv && run, video_lv && run});
            pclk = hrosc_if_i.pixel_clock_out;
            @(posedge core_clk);
            #1;
            chk({15'h0, hrosc_if_i.pixel_clock_out ^ pclk}, {15'h0, run});
        end
        if (kind != 2) begin
            for (int i = 0; i < 1000 && serial_ok !== 1'b1; i++) @(posedge core_clk);
            chk({15'h0, serial_ok}, 16'h0001);
            chk({15'h0, (cyc - t_rel) >= 100 * 2 * CLK_DIV}, 16'h0001);
        end
    endtask : round
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        tally_and_finish;
    end
    initial begin
        {nrst, reset_req, addr_sel, sync_req, standby_req, soft_reset_req} = 6'h00;
        {fw_release_sensor, video_used, stream_en, trigger_used, video_fv, video_lv} = 6'h00;
        {strap, gpio_drive, gpio_used} = 12'h000;
        video_data = 16'h0000;
        round(1);
        for (int i = 0; i < 6; i++) round(i % 3);
        tally_and_finish;
    end
endmodule : hrosc_tb_top
